// ---- verilog/mmap_pkg.sv ----
// constants, types and decode windows for the system memory map decoder
package mmap_pkg;

  localparam logic [31:0] FLASH_BASE      = 32'h0000_0000;
  localparam logic [31:0] FLASH_LAST      = 32'h0003_FFFF;
  localparam logic [31:0] CODE_LAST       = 32'h1FFF_FFFF;
  localparam logic [31:0] RESET_VECTOR    = 32'h0000_0000;
  localparam logic [31:0] SRAM_BASE       = 32'h2000_0000;
  localparam logic [31:0] SRAM_LAST       = 32'h2001_7FFF;
  localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] SRAM_ALIAS_LAST = 32'h23FF_FFFF;
  localparam logic [31:0] PERI_BASE       = 32'h4000_0000;
  localparam logic [31:0] APB_LAST        = 32'h400F_FFFF;
  localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
  localparam logic [31:0] PERI_ALIAS_LAST = 32'h43FF_FFFF;
  localparam logic [31:0] PPB_BASE        = 32'hE000_0000;
  localparam logic [31:0] PPB_LAST        = 32'hE00F_FFFF;
  localparam logic [31:0] APB_OFFSET_MASK = 32'h000F_FFFF;
  localparam logic [1:0]  SIZE_BYTE       = 2'h0;
  localparam logic [1:0]  SIZE_HALF       = 2'h1;
  localparam logic [1:0]  SIZE_WORD       = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOOK = 3'h1,
    ST_FILL = 3'h2,
    ST_ACC  = 3'h3,
    ST_RMW  = 3'h4,
    ST_RESP = 3'h5
  } state_t;

  typedef enum logic [1:0] {
    T_SRAM = 2'h0,
    T_APB  = 2'h1,
    T_PPB  = 2'h2
  } target_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [1:0]  size;
    logic        write;
    logic [31:0] wdata;
    logic        priv;
    logic        debug;
    logic        fetch;
  } req_t;

  typedef struct packed {
    logic        ready;
    logic        err;
    logic [31:0] rdata;
  } rsp_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [1:0]  size;
    logic        write;
    logic [31:0] wdata;
  } slv_req_t;

  typedef struct packed {
    logic        ready;
    logic        hit;
    logic [31:0] rdata;
  } cache_rsp_t;

  typedef struct packed {
    target_t     tgt;
    logic        err;
    logic        bitband;
    logic [31:0] addr;
    logic [4:0]  bitpos;
  } dec_t;

endpackage

// ---- verilog/memory_map_bitband_decoder.sv ----
// system address decoder with bit-band alias translation and peripheral bridge routing
`timescale 1ns/1ps
`default_nettype none
module memory_map_bitband_decoder (
  input  wire logic                 CLOCK_IN,
  input  wire logic                 RESET_N_IN,
  input  wire mmap_pkg::req_t       IFETCH_REQ_IN,
  output mmap_pkg::rsp_t            IFETCH_RSP_OUT,
  input  wire mmap_pkg::req_t       DFETCH_REQ_IN,
  output mmap_pkg::rsp_t            DFETCH_RSP_OUT,
  input  wire mmap_pkg::req_t       SYS_REQ_IN,
  output mmap_pkg::rsp_t            SYS_RSP_OUT,
  input  wire mmap_pkg::req_t       DMA_REQ_IN,
  output mmap_pkg::rsp_t            DMA_RSP_OUT,
  output mmap_pkg::slv_req_t        CACHE_REQ_OUT,
  input  wire mmap_pkg::cache_rsp_t CACHE_RSP_IN,
  output mmap_pkg::slv_req_t        CACHE_FILL_OUT,
  output mmap_pkg::slv_req_t        FLASH_I_REQ_OUT,
  input  wire mmap_pkg::rsp_t       FLASH_I_RSP_IN,
  output mmap_pkg::slv_req_t        FLASH_D_REQ_OUT,
  input  wire mmap_pkg::rsp_t       FLASH_D_RSP_IN,
  output mmap_pkg::slv_req_t        SRAM_REQ_OUT,
  input  wire mmap_pkg::rsp_t       SRAM_RSP_IN,
  output mmap_pkg::slv_req_t        APB_REQ_OUT,
  input  wire mmap_pkg::rsp_t       APB_RSP_IN,
  output mmap_pkg::slv_req_t        PPB_REQ_OUT,
  input  wire mmap_pkg::rsp_t       PPB_RSP_IN
);

  // ==========================================================================
  // helpers
  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic is_flash(input logic [31:0] a);
    is_flash = in_rng(a, mmap_pkg::FLASH_BASE, mmap_pkg::FLASH_LAST);
  endfunction

  function automatic logic [31:0] alias_word(input logic [31:0] base, input logic [31:0] a);
    alias_word = base + {12'h000, a[24:7], 2'h0};
  endfunction

  // system-side decode shared by core system port and dma
  function automatic mmap_pkg::dec_t decode_sys(input mmap_pkg::req_t r, input logic core);
    mmap_pkg::dec_t d;
    logic [31:0]    p;
    d        = '0;
    d.tgt    = mmap_pkg::T_SRAM;
    d.err    = 1'b1;
    d.addr   = r.addr;
    d.bitpos = r.addr[6:2];
    p        = '0;
    if (in_rng(r.addr, mmap_pkg::SRAM_BASE, mmap_pkg::SRAM_LAST)) begin
      d.err = 1'b0;
    end else if (in_rng(r.addr, mmap_pkg::SRAM_ALIAS_BASE, mmap_pkg::SRAM_ALIAS_LAST)) begin
      p = alias_word(mmap_pkg::SRAM_BASE, r.addr);
      if (core && p <= mmap_pkg::SRAM_LAST) begin
        d.err     = 1'b0;
        d.bitband = 1'b1;
        d.addr    = p;
      end
    end else if (in_rng(r.addr, mmap_pkg::PERI_BASE, mmap_pkg::APB_LAST)) begin
      if (r.size == mmap_pkg::SIZE_WORD && r.addr[1:0] == 2'h0) begin
        d.err  = 1'b0;
        d.tgt  = mmap_pkg::T_APB;
        d.addr = mmap_pkg::PERI_BASE + (r.addr & mmap_pkg::APB_OFFSET_MASK);
      end
    end else if (in_rng(r.addr, mmap_pkg::PERI_ALIAS_BASE, mmap_pkg::PERI_ALIAS_LAST)) begin
      if (core) begin
        d.err     = 1'b0;
        d.bitband = 1'b1;
        d.tgt     = mmap_pkg::T_APB;
        d.addr    = alias_word(mmap_pkg::PERI_BASE, r.addr);
      end
    end else if (in_rng(r.addr, mmap_pkg::PPB_BASE, mmap_pkg::PPB_LAST)) begin
      if (core && (r.priv || r.debug)) begin
        d.err = 1'b0;
        d.tgt = mmap_pkg::T_PPB;
      end
    end
    decode_sys = d;
  endfunction

  function automatic mmap_pkg::slv_req_t route(input mmap_pkg::slv_req_t q, input logic sel);
    route       = q;
    route.valid = q.valid && sel;
  endfunction

  // ==========================================================================
  // instruction fetch path: cache lookup, flash fill on miss
  mmap_pkg::state_t   i_st_q, i_st_d;
  logic [31:0]        i_addr_q, i_addr_d;
  logic               i_err_q, i_err_d;
  logic [31:0]        i_rdata_q, i_rdata_d;
  mmap_pkg::slv_req_t fill_q, fill_d;

  always_comb begin
    i_st_d    = i_st_q;
    i_addr_d  = i_addr_q;
    i_err_d   = i_err_q;
    i_rdata_d = i_rdata_q;
    fill_d    = '0;
    case (i_st_q)
      mmap_pkg::ST_IDLE: begin
        if (IFETCH_REQ_IN.valid) begin
          i_addr_d = IFETCH_REQ_IN.addr;
          if (is_flash(IFETCH_REQ_IN.addr)) begin
            i_st_d = mmap_pkg::ST_LOOK;
          end else begin
            i_err_d   = 1'b1;
            i_rdata_d = '0;
            i_st_d    = mmap_pkg::ST_RESP;
          end
        end
      end
      mmap_pkg::ST_LOOK: begin
        if (CACHE_RSP_IN.ready) begin
          if (CACHE_RSP_IN.hit) begin
            i_err_d   = 1'b0;
            i_rdata_d = CACHE_RSP_IN.rdata;
            i_st_d    = mmap_pkg::ST_RESP;
          end else begin
            i_st_d = mmap_pkg::ST_FILL;
          end
        end
      end
      mmap_pkg::ST_FILL: begin
        if (FLASH_I_RSP_IN.ready) begin
          i_err_d      = FLASH_I_RSP_IN.err;
          i_rdata_d    = FLASH_I_RSP_IN.rdata;
          fill_d.valid = !FLASH_I_RSP_IN.err;
          fill_d.addr  = i_addr_q;
          fill_d.size  = mmap_pkg::SIZE_WORD;
          fill_d.write = 1'b1;
          fill_d.wdata = FLASH_I_RSP_IN.rdata;
          i_st_d       = mmap_pkg::ST_RESP;
        end
      end
      mmap_pkg::ST_RESP: i_st_d = mmap_pkg::ST_IDLE;
      default:           i_st_d = mmap_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      i_st_q    <= mmap_pkg::ST_IDLE;
      i_addr_q  <= mmap_pkg::RESET_VECTOR;
      i_err_q   <= 1'b0;
      i_rdata_q <= '0;
      fill_q    <= '0;
    end else begin
      i_st_q    <= i_st_d;
      i_addr_q  <= i_addr_d;
      i_err_q   <= i_err_d;
      i_rdata_q <= i_rdata_d;
      fill_q    <= fill_d;
    end
  end

  // ==========================================================================
  // data fetch path into code space
  mmap_pkg::state_t   d_st_q, d_st_d;
  mmap_pkg::slv_req_t d_req_q, d_req_d;
  logic               d_err_q, d_err_d;
  logic [31:0]        d_rdata_q, d_rdata_d;

  always_comb begin
    d_st_d    = d_st_q;
    d_req_d   = d_req_q;
    d_err_d   = d_err_q;
    d_rdata_d = d_rdata_q;
    case (d_st_q)
      mmap_pkg::ST_IDLE: begin
        if (DFETCH_REQ_IN.valid) begin
          if (is_flash(DFETCH_REQ_IN.addr)) begin
            d_req_d = '{1'b1, DFETCH_REQ_IN.addr, DFETCH_REQ_IN.size, DFETCH_REQ_IN.write, DFETCH_REQ_IN.wdata};
            d_st_d  = mmap_pkg::ST_ACC;
          end else begin
            d_err_d   = 1'b1;
            d_rdata_d = '0;
            d_st_d    = mmap_pkg::ST_RESP;
          end
        end
      end
      mmap_pkg::ST_ACC: begin
        if (FLASH_D_RSP_IN.ready) begin
          d_req_d.valid = 1'b0;
          d_err_d       = FLASH_D_RSP_IN.err;
          d_rdata_d     = FLASH_D_RSP_IN.rdata;
          d_st_d        = mmap_pkg::ST_RESP;
        end
      end
      mmap_pkg::ST_RESP: d_st_d = mmap_pkg::ST_IDLE;
      default:           d_st_d = mmap_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      d_st_q    <= mmap_pkg::ST_IDLE;
      d_req_q   <= '0;
      d_err_q   <= 1'b0;
      d_rdata_q <= '0;
    end else begin
      d_st_q    <= d_st_d;
      d_req_q   <= d_req_d;
      d_err_q   <= d_err_d;
      d_rdata_q <= d_rdata_d;
    end
  end

  // ==========================================================================
  // system path shared by core system port and dma, core first
  mmap_pkg::state_t   s_st_q, s_st_d;
  mmap_pkg::target_t  tgt_q, tgt_d;
  mmap_pkg::slv_req_t s_req_q, s_req_d;
  logic               gnt_dma_q, gnt_dma_d;
  logic               wr_q, wr_d;
  logic               wbit_q, wbit_d;
  logic [4:0]         bit_q, bit_d;
  logic               s_err_q, s_err_d;
  logic [31:0]        s_rdata_q, s_rdata_d;
  mmap_pkg::rsp_t     s_rsp;
  mmap_pkg::req_t     s_cur;
  mmap_pkg::dec_t     s_dec;

  always_comb begin
    case (tgt_q)
      mmap_pkg::T_APB: s_rsp = APB_RSP_IN;
      mmap_pkg::T_PPB: s_rsp = PPB_RSP_IN;
      default:         s_rsp = SRAM_RSP_IN;
    endcase
  end

  always_comb begin
    s_st_d    = s_st_q;
    tgt_d     = tgt_q;
    s_req_d   = s_req_q;
    gnt_dma_d = gnt_dma_q;
    wr_d      = wr_q;
    wbit_d    = wbit_q;
    bit_d     = bit_q;
    s_err_d   = s_err_q;
    s_rdata_d = s_rdata_q;
    s_cur     = SYS_REQ_IN.valid ? SYS_REQ_IN : DMA_REQ_IN;
    s_dec     = decode_sys(s_cur, SYS_REQ_IN.valid);
    case (s_st_q)
      mmap_pkg::ST_IDLE: begin
        if (SYS_REQ_IN.valid || DMA_REQ_IN.valid) begin
          gnt_dma_d = !SYS_REQ_IN.valid;
          tgt_d     = s_dec.tgt;
          bit_d     = s_dec.bitpos;
          wr_d      = s_cur.write;
          wbit_d    = s_cur.wdata[0];
          if (s_dec.err) begin
            s_err_d   = 1'b1;
            s_rdata_d = '0;
            s_st_d    = mmap_pkg::ST_RESP;
          end else begin
            s_req_d.valid = 1'b1;
            s_req_d.addr  = s_dec.addr;
            s_req_d.write = s_cur.write && !s_dec.bitband;
            s_req_d.size  = s_dec.bitband ? mmap_pkg::SIZE_WORD : s_cur.size;
            s_req_d.wdata = s_cur.wdata;
            s_st_d        = s_dec.bitband ? mmap_pkg::ST_RMW : mmap_pkg::ST_ACC;
          end
        end
      end
      mmap_pkg::ST_ACC: begin
        if (s_rsp.ready) begin
          s_req_d.valid = 1'b0;
          s_err_d       = s_rsp.err;
          s_rdata_d     = wr_q ? 32'h0000_0000 : s_rsp.rdata;
          s_st_d        = mmap_pkg::ST_RESP;
        end
      end
      mmap_pkg::ST_RMW: begin
        if (s_rsp.ready) begin
          if (s_rsp.err || !wr_q) begin
            s_req_d.valid = 1'b0;
            s_err_d       = s_rsp.err;
            s_rdata_d     = {31'h0000_0000, s_rsp.rdata[bit_q]};
            s_st_d        = mmap_pkg::ST_RESP;
          end else begin
            s_req_d.write    = 1'b1;
            s_req_d.wdata    = s_rsp.rdata;
            s_req_d.wdata[bit_q] = wbit_q;
            s_st_d           = mmap_pkg::ST_ACC;
          end
        end
      end
      mmap_pkg::ST_RESP: s_st_d = mmap_pkg::ST_IDLE;
      default:           s_st_d = mmap_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      s_st_q    <= mmap_pkg::ST_IDLE;
      tgt_q     <= mmap_pkg::T_SRAM;
      s_req_q   <= '0;
      gnt_dma_q <= 1'b0;
      wr_q      <= 1'b0;
      wbit_q    <= 1'b0;
      bit_q     <= 5'h00;
      s_err_q   <= 1'b0;
      s_rdata_q <= '0;
    end else begin
      s_st_q    <= s_st_d;
      tgt_q     <= tgt_d;
      s_req_q   <= s_req_d;
      gnt_dma_q <= gnt_dma_d;
      wr_q      <= wr_d;
      wbit_q    <= wbit_d;
      bit_q     <= bit_d;
      s_err_q   <= s_err_d;
      s_rdata_q <= s_rdata_d;
    end
  end

  // ==========================================================================
  // outputs
  assign IFETCH_RSP_OUT  = '{i_st_q == mmap_pkg::ST_RESP, i_err_q, i_rdata_q};
  assign DFETCH_RSP_OUT  = '{d_st_q == mmap_pkg::ST_RESP, d_err_q, d_rdata_q};
  assign SYS_RSP_OUT     = '{s_st_q == mmap_pkg::ST_RESP && !gnt_dma_q, s_err_q, s_rdata_q};
  assign DMA_RSP_OUT     = '{s_st_q == mmap_pkg::ST_RESP && gnt_dma_q, s_err_q, s_rdata_q};
  assign CACHE_REQ_OUT   = '{i_st_q == mmap_pkg::ST_LOOK, i_addr_q, mmap_pkg::SIZE_WORD, 1'b0, 32'h0000_0000};
  assign CACHE_FILL_OUT  = fill_q;
  assign FLASH_I_REQ_OUT = '{i_st_q == mmap_pkg::ST_FILL, i_addr_q, mmap_pkg::SIZE_WORD, 1'b0, 32'h0000_0000};
  assign FLASH_D_REQ_OUT = d_req_q;
  assign SRAM_REQ_OUT    = route(s_req_q, tgt_q == mmap_pkg::T_SRAM);
  assign APB_REQ_OUT     = route(s_req_q, tgt_q == mmap_pkg::T_APB);
  assign PPB_REQ_OUT     = route(s_req_q, tgt_q == mmap_pkg::T_PPB);

  // ==========================================================================
  // checks
  a_dma_alias_err: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    s_st_q == mmap_pkg::ST_IDLE && !SYS_REQ_IN.valid && DMA_REQ_IN.valid
    && in_rng(DMA_REQ_IN.addr, mmap_pkg::SRAM_ALIAS_BASE, mmap_pkg::SRAM_ALIAS_LAST)
    |=> !SRAM_REQ_OUT.valid && DMA_RSP_OUT.ready && DMA_RSP_OUT.err)
    else $error("dma alias access not refused");
  a_peri_alias_dma: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    s_st_q == mmap_pkg::ST_IDLE && !SYS_REQ_IN.valid && DMA_REQ_IN.valid
    && in_rng(DMA_REQ_IN.addr, mmap_pkg::PERI_ALIAS_BASE, mmap_pkg::PERI_ALIAS_LAST)
    |=> DMA_RSP_OUT.err && !APB_REQ_OUT.valid)
    else $error("dma peripheral alias not refused");
  a_apb_narrow_err: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    s_st_q == mmap_pkg::ST_IDLE && SYS_REQ_IN.valid && SYS_REQ_IN.size != mmap_pkg::SIZE_WORD
    && in_rng(SYS_REQ_IN.addr, mmap_pkg::PERI_BASE, mmap_pkg::APB_LAST)
    |=> SYS_RSP_OUT.ready && SYS_RSP_OUT.err ##1 !APB_REQ_OUT.valid)
    else $error("narrow bridge access not refused");
  a_ppb_unpriv: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    s_st_q == mmap_pkg::ST_IDLE && SYS_REQ_IN.valid && !SYS_REQ_IN.priv && !SYS_REQ_IN.debug
    && in_rng(SYS_REQ_IN.addr, mmap_pkg::PPB_BASE, mmap_pkg::PPB_LAST)
    |=> SYS_RSP_OUT.err && !PPB_REQ_OUT.valid)
    else $error("unprivileged private access not refused");
  a_ppb_dma_block: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    PPB_REQ_OUT.valid |-> !gnt_dma_q)
    else $error("dma reached private area");
  a_code_hole_err: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    i_st_q == mmap_pkg::ST_IDLE && IFETCH_REQ_IN.valid && !is_flash(IFETCH_REQ_IN.addr)
    |=> IFETCH_RSP_OUT.ready && IFETCH_RSP_OUT.err && !CACHE_REQ_OUT.valid)
    else $error("fetch outside flash not refused");
  a_miss_fill: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    CACHE_REQ_OUT.valid && CACHE_RSP_IN.ready && !CACHE_RSP_IN.hit
    |=> FLASH_I_REQ_OUT.valid && FLASH_I_REQ_OUT.addr == $past(i_addr_q))
    else $error("cache miss did not start fill");
  a_bit_set_clr: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    s_st_q == mmap_pkg::ST_RMW && s_rsp.ready && !s_rsp.err && wr_q
    |=> s_req_q.write && s_req_q.wdata[bit_q] == wbit_q && s_st_q == mmap_pkg::ST_ACC)
    else $error("bit-band write value wrong");
  a_bit_read: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    s_st_q == mmap_pkg::ST_RMW && s_rsp.ready && !wr_q
    |=> s_st_q == mmap_pkg::ST_RESP && s_rdata_q[31:1] == 31'h0000_0000)
    else $error("bit-band read not single bit");
  a_apb_address: assert property (@(posedge CLOCK_IN) disable iff (!RESET_N_IN)
    APB_REQ_OUT.valid |-> in_rng(APB_REQ_OUT.addr, mmap_pkg::PERI_BASE, mmap_pkg::APB_LAST))
    else $error("bridge address outside window");

endmodule
`default_nettype wire

// ---- bench/slave_model.sv ----
// responder model for one slave port of the decoder
`timescale 1ns/1ps
`default_nettype none
module slave_model #(
  parameter int LAT = 0
) (
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire mmap_pkg::slv_req_t req_in,
  output var  mmap_pkg::rsp_t     rsp_out
);
  logic [31:0] mem [logic [29:0]];
  int          cnt;
  initial rsp_out = '0;
  // ==========================================
  // answer after LAT waits, data scrambled when idle
  always @(posedge clk_in) begin
    rsp_out.ready <= 1'b0;
    rsp_out.err   <= 1'b0;
    rsp_out.rdata <= ~rsp_out.rdata;
    if (!rst_n_in) begin
      cnt <= 0;
    end else if (req_in.valid === 1'b1 && !rsp_out.ready) begin
      if (cnt == LAT) begin
        cnt           <= 0;
        rsp_out.ready <= 1'b1;
        if (req_in.write) begin
          mem[req_in.addr[31:2]] = req_in.wdata;
          rsp_out.rdata <= 32'h0;
        end else begin
          rsp_out.rdata <= mem.exists(req_in.addr[31:2]) ? mem[req_in.addr[31:2]] : ~{req_in.addr[31:2], 2'h0};
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  int                   errors = 0;
  int                   total_checks = 0;
  mmap_pkg::req_t       req [4];
  mmap_pkg::rsp_t       rsp [4];
  mmap_pkg::slv_req_t   cache_req, cache_fill, fi_req, fd_req, sram_req, apb_req, ppb_req;
  mmap_pkg::rsp_t       fi_rsp, fd_rsp, sram_rsp, apb_rsp, ppb_rsp;
  mmap_pkg::cache_rsp_t cache_rsp = '0;
  logic [31:0]          cmem [logic [29:0]];
  logic [31:0]          ea [10] = '{32'h0004_0000, 32'h1000_0000, 32'h2001_8000, 32'h2200_0000, 32'h4200_0000,
                                    32'hE000_ED00, 32'hE000_E010, 32'h4000_0001, 32'h4000_0002, 32'h4000_0006};
  int                   ep [10] = '{1, 0, 2, 3, 3, 3, 2, 2, 2, 2};
  logic [1:0]           es [10] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h2};
  logic                 ev [10] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

  always #2 clk = ~clk;

  memory_map_bitband_decoder dut (
    .CLOCK_IN(clk), .RESET_N_IN(rst_n),
    .IFETCH_REQ_IN(req[0]), .IFETCH_RSP_OUT(rsp[0]), .DFETCH_REQ_IN(req[1]), .DFETCH_RSP_OUT(rsp[1]),
    .SYS_REQ_IN(req[2]), .SYS_RSP_OUT(rsp[2]), .DMA_REQ_IN(req[3]), .DMA_RSP_OUT(rsp[3]),
    .CACHE_REQ_OUT(cache_req), .CACHE_RSP_IN(cache_rsp), .CACHE_FILL_OUT(cache_fill),
    .FLASH_I_REQ_OUT(fi_req), .FLASH_I_RSP_IN(fi_rsp), .FLASH_D_REQ_OUT(fd_req), .FLASH_D_RSP_IN(fd_rsp),
    .SRAM_REQ_OUT(sram_req), .SRAM_RSP_IN(sram_rsp), .APB_REQ_OUT(apb_req), .APB_RSP_IN(apb_rsp),
    .PPB_REQ_OUT(ppb_req), .PPB_RSP_IN(ppb_rsp));

  slave_model #(.LAT(1)) m_fi (.clk_in(clk), .rst_n_in(rst_n), .req_in(fi_req), .rsp_out(fi_rsp));
  slave_model #(.LAT(0)) m_fd (.clk_in(clk), .rst_n_in(rst_n), .req_in(fd_req), .rsp_out(fd_rsp));
  slave_model #(.LAT(0)) m_sr (.clk_in(clk), .rst_n_in(rst_n), .req_in(sram_req), .rsp_out(sram_rsp));
  slave_model #(.LAT(3)) m_ap (.clk_in(clk), .rst_n_in(rst_n), .req_in(apb_req), .rsp_out(apb_rsp));
  slave_model #(.LAT(2)) m_pp (.clk_in(clk), .rst_n_in(rst_n), .req_in(ppb_req), .rsp_out(ppb_rsp));

  // ==========================================
  // cache model: hit once a fill has landed
  always @(posedge clk) begin
    cache_rsp.ready <= 1'b0;
    cache_rsp.rdata <= ~cache_rsp.rdata;
    if (cache_req.valid === 1'b1 && !cache_rsp.ready) begin
      cache_rsp.ready <= 1'b1;
      cache_rsp.hit   <= cmem.exists(cache_req.addr[31:2]);
      cache_rsp.rdata <= cmem.exists(cache_req.addr[31:2]) ? cmem[cache_req.addr[31:2]] : 32'h0;
    end
    if (cache_fill.valid === 1'b1) begin
      cmem[cache_fill.addr[31:2]] = cache_fill.wdata;
    end
  end

  // ==========================================
  // tasks
  function automatic logic [31:0] fresh(input logic [31:0] a);
    return ~{a[31:2], 2'h0};
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic acc(input int p, input logic [31:0] a, input logic [1:0] sz, input logic w, input logic [31:0] d,
                     input logic pv, input logic dg, input logic ee, input logic [31:0] er, input string nm);
    int n;
    @(posedge clk);
    req[p] <= '{valid: 1'b1, addr: a, size: sz, write: w, wdata: d, priv: pv, debug: dg, fetch: (p == 0)};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp[p].ready !== 1'b1 && n < 60);
    req[p].valid <= 1'b0;
    if (rsp[p].ready !== 1'b1) begin
      errors++;
      give_verdict();
    end
    chk({nm, " err"}, {31'h0, rsp[p].err}, {31'h0, ee});
    chk({nm, " data"}, rsp[p].rdata, er);
  endtask

  task automatic wr(input int p, input logic [31:0] a, input logic [31:0] d, input string nm);
    acc(p, a, mmap_pkg::SIZE_WORD, 1'b1, d, 1'b1, 1'b0, 1'b0, 32'h0, nm);
  endtask

  task automatic rd(input int p, input logic [31:0] a, input logic [31:0] er, input string nm);
    acc(p, a, mmap_pkg::SIZE_WORD, 1'b0, 32'h0, 1'b1, 1'b0, 1'b0, er, nm);
  endtask

  // ==========================================
  // main sequence
  initial begin
    logic [31:0] a, w, pb, ab, al;
    int          b;
    for (int i = 0; i < 4; i++) req[i] = '0;
    void'($urandom(66579));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(0, mmap_pkg::RESET_VECTOR, fresh(32'h0), "vector miss");
    rd(0, mmap_pkg::RESET_VECTOR, fresh(32'h0), "vector hit");
    fork
      rd(0, 32'h0003_FFFC, fresh(32'h0003_FFFC), "ifetch top");
      rd(1, 32'h0003_FFFC, fresh(32'h0003_FFFC), "dfetch top");
    join
    for (int i = 0; i < 6; i++) begin
      a = mmap_pkg::SRAM_BASE + (($urandom % 32'h0001_8000) & 32'h0001_FFFC);
      w = $urandom;
      wr(2, a, w, "sram wr");
      rd(3, a, w, "dma rd");
      wr(3, a, ~w, "dma wr");
      rd(2, a, ~w, "sram rd");
      a = mmap_pkg::PERI_BASE + (($urandom % 32'h0010_0000) & 32'h000F_FFFC);
      wr(2, a, w, "apb wr");
      rd(2, a, w, "apb rd");
    end
    for (int k = 0; k < 4; k++) begin
      pb = k[0] ? mmap_pkg::PERI_BASE : mmap_pkg::SRAM_BASE;
      ab = k[0] ? mmap_pkg::PERI_ALIAS_BASE : mmap_pkg::SRAM_ALIAS_BASE;
      a  = $urandom % (k[0] ? 32'h0004_0000 : 32'h0000_6000);
      b  = $urandom % 32;
      al = ab + a * 128 + b * 4;
      a  = pb + a * 4;
      w  = $urandom;
      wr(2, a, w, "prim wr");
      wr(2, al, 32'h1, "alias set");
      rd(2, a, w | (32'h1 << b), "prim set");
      rd(2, al, 32'h1, "alias rd1");
      wr(2, al, $urandom & 32'hFFFF_FFFE, "alias clr");
      rd(2, a, w & ~(32'h1 << b), "prim clr");
      rd(2, al, 32'h0, "alias rd0");
    end
    wr(2, mmap_pkg::SRAM_BASE, 32'h0, "base clr");
    for (int i = 0; i < 10; i++) begin
      acc(ep[i], ea[i], es[i], 1'b1, 32'hFFFF_FFFF, ev[i], 1'b0, 1'b1, 32'h0, "refused");
    end
    rd(2, mmap_pkg::SRAM_BASE, 32'h0, "no bit op");
    // core and dma together: core served first, dma held then served
    fork
      rd(2, mmap_pkg::SRAM_BASE, 32'h0, "sys first");
      rd(3, mmap_pkg::SRAM_BASE, 32'h0, "dma waits");
    join
    wr(2, 32'h4000_0008, 32'h0000_0000, "apb word ok");
    w = $urandom;
    wr(2, 32'hE000_E010, w, "ppb wr");
    rd(2, 32'hE000_E010, w, "ppb rd");
    acc(2, 32'hE000_E010, mmap_pkg::SIZE_WORD, 1'b0, 32'h0, 1'b0, 1'b1, 1'b0, w, "ppb dbg");
    give_verdict();
  end
endmodule
`default_nettype wire
